//--- include/wdts_defs.svh
`ifndef WDTS_DEFS_SVH
`define WDTS_DEFS_SVH
// Contract
// - reset flag forces reset enable to one
// - no clearing reset enable while flag set
// - four-bit prescale field selects timeout length
// - codes 0..9 give 2048 doubling to 1048576
// - nominal periods 16 ms up to 8.0 s
// - codes above nine reserved, no timeout
// - timeout interrupt goes to vector 7, 0x0006
// - watchdog reset uses reset vector 0x0000
// - unlock needed; unlock self-clears after four cycles
// - interrupt first, then reset on next timeout
// - reset flag set by watchdog reset, zero clears

// ================================================================
// register word indices (byte address = index * 4)
`define WDTS_IDX_CTRL   6'h00
`define WDTS_IDX_CAUSE  6'h01
`define WDTS_IDX_STAT   6'h02
`define WDTS_IDX_MASK   6'h03
`define WDTS_IDX_CMD    6'h04
`define WDTS_ADR_WORD   7:2
`define WDTS_ADR_LANE   1:0

// ================================================================
// field positions
`define WDTS_CTRL_IFLAG 7
`define WDTS_CTRL_IEN   6
`define WDTS_CTRL_P3    5
`define WDTS_CTRL_UNLK  4
`define WDTS_CTRL_REN   3
`define WDTS_CTRL_PLO   2:0
`define WDTS_CAUSE_RFLAG 3
`define WDTS_CMD_RESTART 0
`define WDTS_EVT_W      3
`define WDTS_EVT_TMO    0
`define WDTS_EVT_RST    1
`define WDTS_EVT_RSVD   2

// ================================================================
// reset values and codes
`define WDTS_PRESC_RST  4'h0
`define WDTS_CODE_MAX   4'h9
`define WDTS_BASE_CYC   21'h000800
`define WDTS_UNLOCK_CYC 3'h4

// ================================================================
// timing: the oscillator tick is derived from the 10 MHz clock
`define WDTS_CLK_NS     100
`define WDTS_T_MIN_MS   16
`define WDTS_T_MAX_MS   8000
`define WDTS_OSC_DIV    ((`WDTS_T_MIN_MS * 1000000 / `WDTS_CLK_NS) / 2048)

// ================================================================
// vectors
`define WDTS_VEC_RST_ADR 16'h0000
`define WDTS_VEC_IRQ_ADR 16'h0006
`define WDTS_VEC_RST_NUM 5'h01
`define WDTS_VEC_IRQ_NUM 5'h07
`endif

//--- include/wdts_pkg.sv
package wdts_pkg;
  // watchdog operating mode, {reset enable, irq enable}
  typedef enum logic [1:0] {
    wdts_stopped   = 2'b00,
    wdts_irq       = 2'b01,
    wdts_reset     = 2'b10,
    wdts_irq_reset = 2'b11
  } wdts_mode_t;
endpackage

//--- core/wdts_timeout_counter.sv
`timescale 1ns/100ps
`include "wdts_defs.svh"
module wdts_timeout_counter
  import wdts_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       restart_i,
  input  wire logic       run_i,
  input  wire logic [3:0] code_i,
  output logic            timeout_o,
  output logic            code_ok_o
);
  // ================================================================
  // limit decode
  logic [20:0] count;
  wire  [20:0] limit;
  wire         hit;

  // 2048 ticks doubled per code step; 2048 ticks is nominally 16 ms
  assign limit     = (`WDTS_BASE_CYC << code_i) - 21'h000001;
  // reserved codes never reach a timeout
  assign code_ok_o = (code_i <= `WDTS_CODE_MAX);
  assign hit       = run_i & code_ok_o & tick_i & (count == limit);

  // ================================================================
  // tick counter, cleared after each timeout
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i || !run_i) begin
      count     <= 21'h000000;
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= hit;
      if (hit) begin
        count <= 21'h000000;
      end else if (tick_i) begin
        count <= count + 21'h000001;
      end
    end
  end
endmodule

//--- core/wdts_top.sv
`timescale 1ns/100ps
`include "wdts_defs.svh"
module wdts_top
  import wdts_pkg::*;
#(
  parameter int OSC_DIV = `WDTS_OSC_DIV
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        always_on_fuse_i,
  input  wire logic        global_irq_en_i,
  input  wire logic        vector_ack_i,
  output logic             irq_o,
  output logic             sys_reset_o,
  output logic             vec_req_o,
  output logic      [4:0]  vec_num_o,
  output logic      [15:0] vec_addr_o
);
  // ================================================================
  // state
  logic       timeout_irq_flag;
  logic       timeout_irq_enable;
  logic [3:0] timeout_prescale_select;
  logic       wd_reset_enable;
  logic [2:0] unlock_cnt;
  logic       wd_reset_flag;
  logic [`WDTS_EVT_W-1:0] evt_status;
  logic [`WDTS_EVT_W-1:0] evt_mask;
  logic       fuse_s1;
  logic       fuse_s2;
  logic       fuse_s3;
  logic       fuse_q;
  logic [15:0] div_cnt;
  logic       osc_tick;
  wdts_mode_t mode;
  logic       act_irq;
  logic       act_reset;

  // divider end count; an OSC_DIV of one gives a tick on every clock
  localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);

  // ================================================================
  // bus decode
  wire        bus_req;
  wire        bus_wr;
  wire [5:0]  word_idx;
  wire        sel_ctrl;
  wire        sel_cause;
  wire        sel_stat;
  wire        sel_mask;
  wire        sel_cmd;
  wire        mapped;
  wire [7:0]  wbyte;
  wire        ctrl_wr;
  wire        cause_wr;
  wire        stat_wr;
  wire        mask_wr;
  wire        cmd_wr;

  // one access per request; answer one cycle after it is seen
  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
  assign word_idx  = wb_adr_i[`WDTS_ADR_WORD];
  assign sel_ctrl  = (word_idx == `WDTS_IDX_CTRL);
  assign sel_cause = (word_idx == `WDTS_IDX_CAUSE);
  assign sel_stat  = (word_idx == `WDTS_IDX_STAT);
  assign sel_mask  = (word_idx == `WDTS_IDX_MASK);
  assign sel_cmd   = (word_idx == `WDTS_IDX_CMD);
  assign mapped    = (wb_adr_i[`WDTS_ADR_LANE] == 2'h0) &
                     (sel_ctrl | sel_cause | sel_stat | sel_mask | sel_cmd);
  assign wbyte     = wb_dat_i[7:0];
  assign ctrl_wr   = bus_wr & mapped & sel_ctrl;
  assign cause_wr  = bus_wr & mapped & sel_cause;
  assign stat_wr   = bus_wr & mapped & sel_stat;
  assign mask_wr   = bus_wr & mapped & sel_mask;
  assign cmd_wr    = bus_wr & mapped & sel_cmd;

  // ================================================================
  // fuse strap synchroniser: accept only when stages two and three agree
  // the strap is asynchronous; one stray sample must not flip the mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_s1 <= 1'b0;
      fuse_s2 <= 1'b0;
      fuse_s3 <= 1'b0;
      fuse_q  <= 1'b0;
    end else begin
      fuse_s1 <= always_on_fuse_i;
      fuse_s2 <= fuse_s1;
      fuse_s3 <= fuse_s2;
      if (fuse_s2 == fuse_s3) begin
        fuse_q <= fuse_s3;
      end
    end
  end

  // ================================================================
  // oscillator tick from the system clock
  // the divider rounds down, so 2048 ticks land a little under 16 ms
  always_ff @(posedge clk_i) begin
    if (rst_i || div_cnt == DIV_LAST) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // registered so the counter sees a clean one-cycle strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= (div_cnt == DIV_LAST);
    end
  end

  // ================================================================
  // mode and effective reset enable
  wire eff_reset_enable;
  wire unlock_open;
  wire running;
  wire timeout;
  wire code_ok;
  wire restart_cmd;
  wire wd_rst_evt;
  wire irq_set_evt;
  wire rsvd_evt;
  wire vack;

  // the flag overrides the stored enable on read and in action
  assign eff_reset_enable = wd_reset_enable | wd_reset_flag;
  assign unlock_open      = (unlock_cnt != 3'h0);
  assign running          = (mode != wdts_stopped);
  assign restart_cmd      = cmd_wr & wbyte[`WDTS_CMD_RESTART];

  // a programmed fuse pins the block in reset mode
  always_comb begin
    if (fuse_q) begin
      mode = wdts_reset;
    end else begin
      mode = wdts_mode_t'({eff_reset_enable, timeout_irq_enable});
    end
  end

  // ================================================================
  // timeout counter
  wdts_timeout_counter u_cnt (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tick_i    (osc_tick),
    .restart_i (restart_cmd | wd_rst_evt),
    .run_i     (running),
    .code_i    (timeout_prescale_select),
    .timeout_o (timeout),
    .code_ok_o (code_ok)
  );

  // ================================================================
  // action on timeout by mode
  // in combined mode an unserviced interrupt escalates to a reset
  always_comb begin
    act_irq   = 1'b0;
    act_reset = 1'b0;
    unique case (mode)
      wdts_stopped: begin
        act_irq   = 1'b0;
      end
      wdts_irq: begin
        act_irq   = timeout;
      end
      wdts_reset: begin
        act_reset = timeout;
      end
      wdts_irq_reset: begin
        act_irq   = timeout & ~timeout_irq_flag;
        act_reset = timeout & timeout_irq_flag;
      end
    endcase
  end

  assign irq_set_evt = act_irq;
  assign wd_rst_evt  = act_reset;
  assign rsvd_evt    = running & ~code_ok;
  // a vector taken with no flag pending changes nothing
  assign vack        = vector_ack_i & timeout_irq_flag;

  // ================================================================
  // next control values; hardware sets win over software clears
  wire       next_iflag;
  wire       next_ien;
  wire [3:0] next_presc;
  wire       next_ren;
  wire [2:0] next_unlock_cnt;
  wire       next_reset_flag;
  wire [`WDTS_EVT_W-1:0] evt_set;
  wire [`WDTS_EVT_W-1:0] next_status;
  wire [`WDTS_EVT_W-1:0] next_mask;
  wire       next_vec_req;
  wire       unlock_req;

  assign next_iflag = wd_rst_evt  ? 1'b0 :
                      irq_set_evt ? 1'b1 :
                      (vack | (ctrl_wr & wbyte[`WDTS_CTRL_IFLAG])) ? 1'b0 :
                      timeout_irq_flag;
  // taking the vector in combined mode drops the enable: next is reset
  assign next_ien   = wd_rst_evt ? 1'b0 :
                      (vack & (mode == wdts_irq_reset)) ? 1'b0 :
                      ctrl_wr ? wbyte[`WDTS_CTRL_IEN] :
                      timeout_irq_enable;
  // prescale changes only inside the unlock window or on a watchdog reset
  assign next_presc = wd_rst_evt ? `WDTS_PRESC_RST :
                      (ctrl_wr & unlock_open) ?
                      {wbyte[`WDTS_CTRL_P3], wbyte[`WDTS_CTRL_PLO]} :
                      timeout_prescale_select;
  // clearing needs the window, and is refused while the flag is set
  assign next_ren   = wd_rst_evt ? 1'b0 :
                      ~ctrl_wr ? wd_reset_enable :
                      unlock_open ? (wbyte[`WDTS_CTRL_REN] | wd_reset_flag) :
                      (wd_reset_enable | wbyte[`WDTS_CTRL_REN]);
  // the window counts down from the unlock write; a fresh unlock re-arms it
  assign unlock_req = ctrl_wr & wbyte[`WDTS_CTRL_UNLK] & wbyte[`WDTS_CTRL_REN];
  assign next_unlock_cnt = wd_rst_evt ? 3'h0 :
                           unlock_req ? `WDTS_UNLOCK_CYC :
                           unlock_open ? (unlock_cnt - 3'h1) : 3'h0;
  assign next_reset_flag = wd_rst_evt ? 1'b1 :
                           (cause_wr & ~wbyte[`WDTS_CAUSE_RFLAG]) ? 1'b0 :
                           wd_reset_flag;

  assign evt_set[`WDTS_EVT_TMO]  = irq_set_evt;
  assign evt_set[`WDTS_EVT_RST]  = wd_rst_evt;
  assign evt_set[`WDTS_EVT_RSVD] = rsvd_evt;
  // a clear that meets a new event in one cycle leaves the bit set
  assign next_status = evt_set |
                       (evt_status & ~(stat_wr ? wbyte[`WDTS_EVT_W-1:0] :
                                                 {`WDTS_EVT_W{1'b0}}));
  assign next_mask   = mask_wr ? wbyte[`WDTS_EVT_W-1:0] : evt_mask;
  assign next_vec_req = next_iflag & next_ien & global_irq_en_i;

  // ================================================================
  // control register state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_irq_flag        <= 1'b0;
      timeout_irq_enable      <= 1'b0;
      timeout_prescale_select <= `WDTS_PRESC_RST;
      wd_reset_enable         <= 1'b0;
      unlock_cnt              <= 3'h0;
    end else begin
      timeout_irq_flag        <= next_iflag;
      timeout_irq_enable      <= next_ien;
      timeout_prescale_select <= next_presc;
      wd_reset_enable         <= next_ren;
      unlock_cnt              <= next_unlock_cnt;
    end
  end

  // ================================================================
  // reset cause flag: survives the watchdog's own reset, power-on clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_reset_flag <= 1'b0;
    end else begin
      wd_reset_flag <= next_reset_flag;
    end
  end

  // ================================================================
  // sticky events and level interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_status <= {`WDTS_EVT_W{1'b0}};
      evt_mask   <= {`WDTS_EVT_W{1'b0}};
      irq_o      <= 1'b0;
    end else begin
      evt_status <= next_status;
      evt_mask   <= next_mask;
      irq_o      <= |(next_status & next_mask);
    end
  end

  // ================================================================
  // vector dispatch and system reset request
  // number and address hold until the next request of either kind
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_o <= 1'b0;
      vec_req_o   <= 1'b0;
      vec_num_o   <= `WDTS_VEC_RST_NUM;
      vec_addr_o  <= `WDTS_VEC_RST_ADR;
    end else begin
      sys_reset_o <= wd_rst_evt;
      vec_req_o   <= next_vec_req;
      if (wd_rst_evt) begin
        vec_num_o  <= `WDTS_VEC_RST_NUM;
        vec_addr_o <= `WDTS_VEC_RST_ADR;
      end else if (next_vec_req) begin
        vec_num_o  <= `WDTS_VEC_IRQ_NUM;
        vec_addr_o <= `WDTS_VEC_IRQ_ADR;
      end
    end
  end

  // ================================================================
  // read mux; unmapped words read zero and still answer
  wire [7:0] ctrl_rd;
  wire [7:0] cause_rd;
  wire [7:0] rd_byte;

  assign ctrl_rd = {timeout_irq_flag, timeout_irq_enable,
                    timeout_prescale_select[3], unlock_open,
                    eff_reset_enable, timeout_prescale_select[`WDTS_CTRL_PLO]};
  // the cause word leaves the other reset sources' bit positions free
  assign cause_rd = 8'(wd_reset_flag) << `WDTS_CAUSE_RFLAG;
  assign rd_byte = ~mapped   ? 8'h00 :
                   sel_ctrl  ? ctrl_rd :
                   sel_cause ? cause_rd :
                   sel_stat  ? {5'h00, evt_status} :
                   sel_mask  ? {5'h00, evt_mask} :
                   {6'h00, mode};

  // ================================================================
  // wishbone answer
  // read data stands until the next read, so a slow master can still take it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= {24'h000000, rd_byte};
      end
    end
  end
endmodule

//--- sim/wdts_checker.sv
`timescale 1ns/100ps
// ==================
// bus, vector and spacing checks on the top ports
module wdts_checker #(
  parameter int OSC_DIV = 1
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        always_on_fuse_i,
  input wire logic        global_irq_en_i,
  input wire logic        vector_ack_i,
  input wire logic        irq_o,
  input wire logic        sys_reset_o,
  input wire logic        vec_req_o,
  input wire logic [4:0]  vec_num_o,
  input wire logic [15:0] vec_addr_o
);
  int   gap;
  logic seen;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // cycles since the last vector or reset request, saturating so it never wraps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap  <= 0;
      seen <= 1'b0;
    end else if (sys_reset_o || $rose(vec_req_o)) begin
      gap  <= 0;
      seen <= 1'b1;
    end else if (gap < 1000000) begin
      gap <= gap + 1;
    end
  end

  // ==================
  // register bus
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");

  // ==================
  // vectors and timeouts
  a_irq_vector: assert property (
    $rose(vec_req_o) |-> ##[0:2] (vec_num_o == 5'h07 && vec_addr_o == 16'h0006))
    else $error("interrupt vector wrong");
  a_reset_vector: assert property (
    sys_reset_o |-> ##[0:2] (vec_num_o == 5'h01 && vec_addr_o == 16'h0000))
    else $error("reset vector wrong");
  a_vec_gated: assert property (!global_irq_en_i |=> !vec_req_o)
    else $error("vector request while interrupts off");
  a_vec_clear: assert property (vector_ack_i |=> !vec_req_o)
    else $error("vector request after vector taken");
  a_reset_pulse: assert property (sys_reset_o |=> !sys_reset_o)
    else $error("reset request held");
  a_reset_spacing: assert property (sys_reset_o && seen |-> gap >= 2040 * OSC_DIV)
    else $error("reset too soon after previous request");

  // main scenarios reached
  c_reset: cover property (sys_reset_o);
  c_vector: cover property ($rose(vec_req_o));
  c_irq: cover property (irq_o);
endmodule

bind wdts_top wdts_checker #(.OSC_DIV(OSC_DIV)) chk (.*);

//--- sim/wdts_bench.sv
`timescale 1ns/100ps
// ==================
// directed bench for the watchdog timeout select block
module wdts_bench;
  logic        clk_i            = 1'b0;
  logic        rst_i            = 1'b1;
  logic        wb_cyc_i         = 1'b0;
  logic        wb_stb_i         = 1'b0;
  logic        wb_we_i          = 1'b0;
  logic [7:0]  wb_adr_i         = 8'h00;
  logic [3:0]  wb_sel_i         = 4'hf;
  logic [31:0] wb_dat_i         = 32'h0;
  logic        always_on_fuse_i = 1'b0;
  logic        global_irq_en_i  = 1'b0;
  logic        vector_ack_i     = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, irq_o, sys_reset_o, vec_req_o;
  logic [4:0]  vec_num_o;
  logic [15:0] vec_addr_o;
  logic [7:0]  rv;
  logic [3:0]  lanes            = 4'hf;
  int          fail_count = 0;
  int          tests_run  = 0;
  int          n;

  // one tick per clock, so code 0 times out after 2048 cycles
  wdts_top #(.OSC_DIV(1)) uut (.*);

  initial forever #50 clk_i = ~clk_i;

  // ==================
  // helpers
  task automatic chk(input string s, input logic [15:0] v, e);
    tests_run++;
    if (v !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask

  // classic cycle: hold until ack is sampled, then release for a cycle
  // no local limit: a missing ack is left to the watchdog below
  task automatic wb(input logic w, input logic [7:0] a, d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= lanes;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rv = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdc(input string s, input logic [7:0] a, e);
    wb(1'b0, a, 8'h00);
    chk(s, 16'(rv), 16'(e));
  endtask

  // wait for a vector request (r=0) or a reset request (r=1), bounded
  task automatic wt(input bit r);
    n = 0;
    while ((r ? sys_reset_o : vec_req_o) !== 1'b1 && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==================
  // scenarios
  task t_reset;
    chk("vec_num", 16'(vec_num_o), 16'h0001);
    chk("vec_addr", vec_addr_o, 16'h0000);
    rdc("ctrl", 8'h00, 8'h00);
    rdc("cause", 8'h04, 8'h00);
    wb(1'b1, 8'h40, 8'hff);
    rdc("unmapped", 8'h40, 8'h00);
    lanes = 4'he;
    wb(1'b1, 8'h0c, 8'h07);
    lanes = 4'hf;
    rdc("lane_off", 8'h0c, 8'h00);
    $display("reset test done");
  endtask

  // interrupt mode: masked event, then unmask, vector taken, status cleared
  task t_irq;
    wb(1'b1, 8'h0c, 8'h00);
    wb(1'b1, 8'h00, 8'h40);
    global_irq_en_i <= 1'b1;
    wb(1'b1, 8'h10, 8'h01);
    wt(1'b0);
    chk("tmo_code0", 16'(n > 2040 && n < 2060), 16'h0001);
    chk("irq_num", 16'(vec_num_o), 16'h0007);
    chk("irq_addr", vec_addr_o, 16'h0006);
    chk("irq_masked", 16'(irq_o), 16'h0000);
    rdc("ctrl_flag", 8'h00, 8'hc0);
    rdc("stat", 8'h08, 8'h01);
    wb(1'b1, 8'h0c, 8'h01);
    @(posedge clk_i);
    chk("irq_raised", 16'(irq_o), 16'h0001);
    vector_ack_i <= 1'b1;
    @(posedge clk_i);
    vector_ack_i <= 1'b0;
    rdc("ctrl_taken", 8'h00, 8'h40);
    wb(1'b1, 8'h08, 8'h01);
    @(posedge clk_i);
    chk("irq_cleared", 16'(irq_o), 16'h0000);
    $display("interrupt test done");
  endtask

  // combined mode: interrupt first, reset on the next timeout
  task t_comb;
    wb(1'b1, 8'h00, 8'h48);
    wb(1'b1, 8'h10, 8'h01);
    wt(1'b0);
    chk("first_tmo", 16'(sys_reset_o), 16'h0000);
    chk("first_len", 16'(n > 2040 && n < 2060), 16'h0001);
    wt(1'b1);
    chk("second_tmo", 16'(n > 2030 && n < 2060), 16'h0001);
    repeat (3) @(posedge clk_i);
    chk("rst_num", 16'(vec_num_o), 16'h0001);
    chk("rst_addr", vec_addr_o, 16'h0000);
    rdc("cause_set", 8'h04, 8'h08);
    rdc("ctrl_forced", 8'h00, 8'h08);
    rdc("mode_forced", 8'h10, 8'h02);
    wb(1'b1, 8'h00, 8'h18);
    wb(1'b1, 8'h00, 8'h00);
    rdc("ctrl_kept", 8'h00, 8'h08);
    wb(1'b1, 8'h04, 8'h00);
    rdc("cause_clr", 8'h04, 8'h00);
    wb(1'b1, 8'h00, 8'h18);
    wb(1'b1, 8'h00, 8'h00);
    rdc("ctrl_off", 8'h00, 8'h00);
    $display("combined test done");
  endtask

  // late write after the unlock window, then a code 1 timeout length
  task t_lock;
    wb(1'b1, 8'h00, 8'h18);
    repeat (6) @(posedge clk_i);
    wb(1'b1, 8'h00, 8'h01);
    rdc("late_write", 8'h00, 8'h08);
    wb(1'b1, 8'h00, 8'h18);
    wb(1'b1, 8'h00, 8'h41);
    rdc("code1", 8'h00, 8'h41);
    wb(1'b1, 8'h10, 8'h01);
    wt(1'b0);
    chk("tmo_code1", 16'(n > 4088 && n < 4108), 16'h0001);
    $display("unlock test done");
  endtask

  // reserved code 10 must never time out
  task t_rsvd;
    wb(1'b1, 8'h00, 8'h18);
    wb(1'b1, 8'h00, 8'he2);
    wb(1'b1, 8'h08, 8'h07);
    wb(1'b1, 8'h10, 8'h01);
    wt(1'b0);
    chk("rsvd_quiet", 16'(vec_req_o), 16'h0000);
    rdc("rsvd_stat", 8'h08, 8'h04);
    always_on_fuse_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdc("fuse_mode", 8'h10, 8'h02);
    $display("reserved test done");
  endtask

  // ==================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_irq;
    t_comb;
    t_lock;
    t_rsvd;
    end_of_test;
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    end_of_test;
  end
endmodule
